// ---- fuc_float_to_unsigned.sv ----
// Float-to-unsigned conversion unit of the floating-point ALU, with the
// processor status word and its APB access.
// Assumes issue logic presents operations synchronous to core_clk and
// only in the lanes that stand for the permitted issue slots.
`timescale 1ns/1ps
`include "fuc_params.svh"

// What this block does
// RULE_01: Opcode 124 is the flag-only conversion using the status rounding mode.
// RULE_02: Opcode 125 is the truncating conversion writing an integer.
// RULE_03: Opcode 126 is the flag-only conversion rounding toward zero.
// RULE_04: One operand, no modifier, result after three cycles, two issue lanes.
// RULE_05: Truncating conversion always rounds toward zero, ignoring mode bits.
// RULE_06: Opcode 124 evaluates with the currently selected rounding mode.
// RULE_07: Truncation flushes a denormal to zero and sets the status flush flag.
// RULE_08: Flag-only operations flush denormals and set the flush bit returned.
// RULE_09: Flag-only operations return a flag vector and leave status untouched.
// RULE_10: Inexact is 0x02, invalid 0x10, flush 0x20; no exception gives zero.
// RULE_11: Opcode 126 returns exactly the flags truncation would raise.
// RULE_12: Exceptions of the truncating conversion set the status flags.
// RULE_13: Status flags are sticky; only an explicit status write clears them.
// RULE_14: Status flags update in the same cycle the result is written.
// RULE_15: Simultaneous flag updates are ORed together with the old value.
// RULE_16: A false guard blocks both destination and status flag updates.
// RULE_17: Flag-only results are written only when the guard is absent or true.
// RULE_18: Any negative source that is neither zero nor denormal gives zero and raises invalid.
// RULE_19: A not-a-number source gives zero and raises invalid.
// RULE_20: Positive infinity saturates to all ones and raises invalid.
// RULE_21: Fully pipelined; a new conversion may issue every cycle per lane.
module fuc_float_to_unsigned #(
   parameter int NUM_SLOTS = 2
) (
   // Clock and reset
   input  wire logic                                core_clk,
   input  wire logic                                rst,
   // APB register access
   input  wire logic                                psel,
   input  wire logic                                penable,
   input  wire logic                                pwrite,
   input  wire logic [`FUC_ADDR_W-1:0]              paddr,
   input  wire logic [31:0]                         pwdata,
   output logic      [31:0]                         prdata,
   output logic                                     pready,
   output logic                                     pslverr,
   // Issue, one lane per permitted slot
   input  wire logic [NUM_SLOTS-1:0]                issueValid,
   input  wire logic [NUM_SLOTS-1:0][`FUC_OP_W-1:0] issueOpcode,
   input  wire logic [NUM_SLOTS-1:0][31:0]          sourceOperand,
   input  wire logic [NUM_SLOTS-1:0]                guardPresent,
   input  wire logic [NUM_SLOTS-1:0]                guardValue,
   // Write-back
   output logic      [NUM_SLOTS-1:0]                destWrite,
   output logic      [NUM_SLOTS-1:0][31:0]          destValue,
   // Status word
   output logic      [31:0]                         processorStatusWord
);

   ////////////////////////////////////////////////////////////////////////
   // Status word fields

   wire fuc_pkg::fuc_round_t statusMode =
      fuc_pkg::fuc_round_t'(processorStatusWord[`FUC_MODE_LSB +:
                                                `FUC_MODE_W]);

   ////////////////////////////////////////////////////////////////////////
   // APB slave

   wire apbSetup    = psel & ~penable;
   wire apbDone     = psel & penable & pready;
   wire hitStatus   = paddr == `FUC_STATUS_OFFSET;
   wire statusWrite = apbDone & pwrite & hitStatus;

   // Read data is captured in the setup cycle, giving a zero-wait access
   // with every APB output straight from a flip-flop.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready <= apbSetup;
         if (apbSetup) begin
            prdata  <= (~pwrite & hitStatus) ? processorStatusWord : 32'h0;
            pslverr <= ~hitStatus;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Conversion lanes

   logic [NUM_SLOTS-1:0][`FUC_FLAG_W-1:0] statusSet;
   logic [NUM_SLOTS-1:0]                  issueGo;

   for (genvar l = 0; l < NUM_SLOTS; l++) begin : g_lane

      wire isFlagsMode  = issueOpcode[l] == `FUC_OP_FLAGS_MODE;  // [RULE_01]
      wire isTrunc      = issueOpcode[l] == `FUC_OP_TRUNC;       // [RULE_02]
      wire isFlagsTrunc = issueOpcode[l] == `FUC_OP_FLAGS_TRUNC; // [RULE_03]
      wire legalOp      = isFlagsMode | isTrunc | isFlagsTrunc;
      wire guardPass    = ~guardPresent[l] | guardValue[l]; // [RULE_16] [RULE_17]

      assign issueGo[l] = issueValid[l] & legalOp & guardPass;

      fuc_pkg::fuc_stage_t next_s1;
      fuc_pkg::fuc_stage_t s1;

      always_comb begin
         next_s1.write      = issueGo[l];
         next_s1.flagsOnly  = ~isTrunc;
         next_s1.setsStatus = isTrunc;                      // [RULE_09]
         next_s1.operand    = sourceOperand[l];
         // Only opcode 124 follows the mode bits; the rest truncate.
         next_s1.mode = isFlagsMode ? statusMode            // [RULE_06]
                                    : fuc_pkg::RND_ZERO;    // [RULE_05] [RULE_11]
      end

      logic [31:0]             convValue;
      logic [`FUC_FLAG_W-1:0]  convFlags;

      fuc_convert_core u_core (
         .sourceOperand (s1.operand),
         .roundMode     (s1.mode),
         .intValue      (convValue),
         .flags         (convFlags)
      );

      logic                    s2Write;
      logic                    s2FlagsOnly;
      logic                    s2SetsStatus;
      logic [31:0]             s2Value;
      logic [`FUC_FLAG_W-1:0]  s2Flags;

      // Three register stages and no shared state keep the lane fully
      // pipelined.
      always_ff @(posedge core_clk or posedge rst) begin  // [RULE_21] [RULE_04]
         if (rst) begin
            s1           <= '0;
            s2Write      <= 1'b0;
            s2FlagsOnly  <= 1'b0;
            s2SetsStatus <= 1'b0;
            s2Value      <= 32'h0;
            s2Flags      <= '0;
            destWrite[l] <= 1'b0;
            destValue[l] <= 32'h0;
         end else begin
            s1           <= next_s1;
            s2Write      <= s1.write;
            s2FlagsOnly  <= s1.flagsOnly;
            s2SetsStatus <= s1.setsStatus;
            s2Value      <= convValue;   // [RULE_18] [RULE_19] [RULE_20]
            s2Flags      <= convFlags;   // [RULE_07] [RULE_08]
            destWrite[l] <= s2Write;
            if (s2Write) begin
               destValue[l] <= s2FlagsOnly ?                  // [RULE_10]
                               {{(32-`FUC_FLAG_W){1'b0}}, s2Flags} :
                               s2Value;
            end
         end
      end

      assign statusSet[l] = (s2Write & s2SetsStatus) ? s2Flags : '0; // [RULE_12]
   end

   ////////////////////////////////////////////////////////////////////////
   // Status word

   logic [`FUC_FLAG_W-1:0] setAll;

   always_comb begin
      setAll = '0;
      for (int l = 0; l < NUM_SLOTS; l++) begin
         setAll = setAll | statusSet[l];                   // [RULE_15]
      end
   end

   // A hardware set in the cycle of a software write wins over the clear.
   wire [31:0] statusBase = statusWrite ? (pwdata & `FUC_STATUS_MASK)
                                        : processorStatusWord;
   wire [31:0] next_status =
      statusBase | ({{(32-`FUC_FLAG_W){1'b0}}, setAll} & `FUC_FLAG_MASK);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         processorStatusWord <= `FUC_STATUS_RESET;
      end else begin
         processorStatusWord <= next_status;  // [RULE_13] [RULE_14]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   // Truncating issues are tracked to the edge at which their flags may
   // land, so a flag-only or guarded-off status change is caught.
   logic [NUM_SLOTS-1:0] truncDone;

   for (genvar l = 0; l < NUM_SLOTS; l++) begin : g_check

      wire truncIssue = issueValid[l] & guardPass_w(l) &
                        (issueOpcode[l] == `FUC_OP_TRUNC);
      wire flagIssue  = issueValid[l] & guardPass_w(l) &
                        ((issueOpcode[l] == `FUC_OP_FLAGS_MODE) |
                         (issueOpcode[l] == `FUC_OP_FLAGS_TRUNC));
      wire [7:0] srcExp  = sourceOperand[l][30:23];
      wire       srcMant = |sourceOperand[l][22:0];

      logic [2:0] truncPipe;

      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            truncPipe <= 3'h0;
         end else begin
            truncPipe <= {truncPipe[1:0], truncIssue};
         end
      end

      assign truncDone[l] = truncPipe[2];

      write_latency_a: assert property ( // [RULE_04]
         destWrite[l] == $past(issueGo[l], 3))
         else $error("write-back not three cycles after issue");

      guard_block_a: assert property ( // [RULE_16]
         issueValid[l] & guardPresent[l] & ~guardValue[l] |->
            ##3 !destWrite[l])
         else $error("false guard still wrote the destination");

      flush_vector_a: assert property ( // [RULE_08]
         flagIssue & (srcExp == 8'h00) & srcMant |->
            ##3 destWrite[l] && destValue[l] == 32'h0000_0020)
         else $error("denormal flag vector is not the flush bit");

      nan_zero_a: assert property ( // [RULE_19]
         truncIssue & (srcExp == 8'hff) & srcMant |->
            ##3 destValue[l] == 32'h0 &&
                processorStatusWord[`FUC_BIT_INVALID])
         else $error("NaN did not give zero with invalid");

      inf_saturate_a: assert property ( // [RULE_20]
         truncIssue & (sourceOperand[l] == 32'h7f80_0000) |->
            ##3 destValue[l] == 32'hffff_ffff &&
                processorStatusWord[`FUC_BIT_INVALID])
         else $error("infinity did not saturate with invalid");

      negative_zero_a: assert property ( // [RULE_18]
         truncIssue & sourceOperand[l][31] & (srcExp != 8'h00) &
         ~((srcExp == 8'hff) & srcMant) |->
            ##3 destValue[l] == 32'h0 &&
                processorStatusWord[`FUC_BIT_INVALID])
         else $error("negative source did not give zero with invalid");

      vector_bits_a: assert property ( // [RULE_10]
         flagIssue |-> ##3 (destValue[l] & ~`FUC_FLAG_MASK) == 32'h0)
         else $error("flag vector has bits outside the flag positions");

      toward_zero_a: assert property ( // [RULE_05]
         truncIssue & (sourceOperand[l] == 32'h4024_7ae1) |->
            ##3 destValue[l] == 32'h2 &&
                processorStatusWord[`FUC_BIT_INEXACT])
         else $error("truncation of 2.57 did not give 2 with inexact");

      flush_status_a: assert property ( // [RULE_07]
         truncIssue & (srcExp == 8'h00) & srcMant |->
            ##3 destValue[l] == 32'h0 &&
                processorStatusWord[`FUC_BIT_FLUSH])
         else $error("denormal truncation did not set the flush flag");

      trunc_write_a: assert property ( // [RULE_02]
         truncIssue |-> ##3 destWrite[l])
         else $error("truncating conversion did not write back");

      flag_write_a: assert property ( // [RULE_17]
         flagIssue |-> ##3 destWrite[l])
         else $error("flag-only operation did not write back");

      bad_opcode_a: assert property ( // [RULE_01] [RULE_02] [RULE_03]
         issueValid[l] & (issueOpcode[l] != `FUC_OP_FLAGS_MODE) &
         (issueOpcode[l] != `FUC_OP_TRUNC) &
         (issueOpcode[l] != `FUC_OP_FLAGS_TRUNC) |-> ##3 !destWrite[l])
         else $error("unknown opcode wrote the destination");

      dest_hold_a: assert property ( // [RULE_16] [RULE_17]
         !destWrite[l] |-> $stable(destValue[l]))
         else $error("destination changed without a write-back");

      exact_zero_a: assert property ( // [RULE_10]
         flagIssue & (sourceOperand[l] == 32'h4040_0000) |->
            ##3 destValue[l] == 32'h0)
         else $error("exact conversion returned a nonzero vector");

      nan_vector_a: assert property ( // [RULE_10]
         flagIssue & (srcExp == 8'hff) & srcMant |->
            ##3 destValue[l] == 32'h0000_0010)
         else $error("NaN flag vector is not invalid alone");

      neg_vector_a: assert property ( // [RULE_11]
         flagIssue & sourceOperand[l][31] & (srcExp != 8'h00) &
         ~((srcExp == 8'hff) & srcMant) |->
            ##3 destValue[l] == 32'h0000_0010)
         else $error("negative flag vector is not invalid alone");

      mode_inexact_a: assert property ( // [RULE_06]
         flagIssue & (sourceOperand[l] == 32'h4024_7ae1) |->
            ##3 destValue[l] == 32'h0000_0002)
         else $error("flag vector of 2.57 is not inexact alone");

      trunc_cover: cover property (truncIssue ##3 destWrite[l]);
      flag_cover:  cover property (flagIssue ##3 destValue[l] != 32'h0);
      guard_cover: cover property (issueValid[l] & guardPresent[l] &
                                   ~guardValue[l]);
   end

   sticky_flags_a: assert property ( // [RULE_13]
      !statusWrite |=> (processorStatusWord[`FUC_FLAG_W-1:0] &
                        $past(processorStatusWord[`FUC_FLAG_W-1:0])) ==
                       $past(processorStatusWord[`FUC_FLAG_W-1:0]))
      else $error("status flag cleared without a status write");

   flag_timing_a: assert property ( // [RULE_14]
      (processorStatusWord[`FUC_FLAG_W-1:0] &
       ~$past(processorStatusWord[`FUC_FLAG_W-1:0])) != '0 &&
      !$past(statusWrite) |-> |destWrite)
      else $error("status flag rose without a write-back");

   trunc_status_a: assert property ( // [RULE_09] [RULE_16]
      (processorStatusWord[`FUC_FLAG_W-1:0] &
       ~$past(processorStatusWord[`FUC_FLAG_W-1:0])) != '0 &&
      !$past(statusWrite) |-> |truncDone)
      else $error("status flag rose without a truncating write-back");

   dual_cover:   cover property (&destWrite);
   status_cover: cover property (statusWrite);

   function automatic logic guardPass_w(input int l);
      return ~guardPresent[l] | guardValue[l];
   endfunction : guardPass_w

endmodule : fuc_float_to_unsigned

// ---- fuc_params.svh ----
// Constants for the float-to-unsigned conversion unit: opcodes, flag
// positions, status word layout and the APB register map.
// Assumes it is included by bare name from the package and the modules.
`ifndef FUC_PARAMS_SVH
`define FUC_PARAMS_SVH

// Operation codes handled by this unit (124, 125, 126).
`define FUC_OP_W            8
`define FUC_OP_FLAGS_MODE   8'h7c
`define FUC_OP_TRUNC        8'h7d
`define FUC_OP_FLAGS_TRUNC  8'h7e

// Cycles from issue to write-back.
`define FUC_LATENCY         3

// Exception bit positions, shared by the status word and flag vectors.
`define FUC_FLAG_W          6
`define FUC_BIT_INEXACT     1
`define FUC_BIT_INVALID     4
`define FUC_BIT_FLUSH       5
`define FUC_FLAG_MASK       32'h0000_0032

// Rounding mode field of the status word.
`define FUC_MODE_LSB        8
`define FUC_MODE_W          2

// Register map.
`define FUC_ADDR_W          12
`define FUC_STATUS_OFFSET   12'h000
`define FUC_STATUS_RESET    32'h0000_0000
`define FUC_STATUS_MASK     32'h0000_0332

`endif

// ---- fuc_pkg.sv ----
// Types shared by the float-to-unsigned conversion unit.
// Assumes fuc_params.svh is on the include path.
`include "fuc_params.svh"

package fuc_pkg;

   // Encoding of the status word rounding mode field.
   typedef enum logic [`FUC_MODE_W-1:0] {
      RND_NEAREST,
      RND_ZERO,
      RND_UP,
      RND_DOWN
   } fuc_round_t;

   // One operation travelling through the first pipeline stage.
   typedef struct packed {
      logic        write;
      logic        flagsOnly;
      logic        setsStatus;
      fuc_round_t  mode;
      logic [31:0] operand;
   } fuc_stage_t;

endpackage : fuc_pkg

// ---- fuc_convert_core.sv ----
// Combinational single-precision to 32-bit unsigned converter.
// Assumes its caller registers inputs and outputs around it.
`timescale 1ns/1ps
`include "fuc_params.svh"

module fuc_convert_core (
   // Operand and rounding mode
   input  wire logic [31:0]             sourceOperand,
   input  wire fuc_pkg::fuc_round_t     roundMode,
   // Integer result and exception vector
   output logic      [31:0]             intValue,
   output logic      [`FUC_FLAG_W-1:0]  flags
);

   wire        signBit   = sourceOperand[31];
   wire [7:0]  expField  = sourceOperand[30:23];
   wire [22:0] fracField = sourceOperand[22:0];

   wire isNan     = (expField == 8'hff) & (|fracField);
   wire isInf     = (expField == 8'hff) & ~(|fracField);
   wire isDenorm  = (expField == 8'h00) & (|fracField);
   wire isZero    = (expField == 8'h00) & ~(|fracField);
   wire normalPos = ~signBit & (expField != 8'h00) & (expField != 8'hff);

   // Values of 2^32 and above cannot be held; below 2^-9 only a sticky
   // bit survives, which keeps the shifter at 64 bits.
   wire tooBig = expField >= 8'h9f;
   wire tiny   = expField < 8'h76;

   wire [5:0]  shiftAmt = (tiny | tooBig) ? 6'h00 : 6'(expField - 8'h76);
   wire [63:0] fixedVal = tiny ? 64'h0 : ({40'h0, 1'b1, fracField} << shiftAmt);

   wire [31:0] intPart   = fixedVal[63:32];
   wire        guardBit  = fixedVal[31];
   wire        stickyBit = tiny | (|fixedVal[30:0]);
   wire        lossy     = guardBit | stickyBit;

   logic roundUp;

   always_comb begin
      unique case (roundMode)
         fuc_pkg::RND_NEAREST: roundUp = guardBit & (stickyBit | intPart[0]);
         fuc_pkg::RND_ZERO:    roundUp = 1'b0;
         fuc_pkg::RND_UP:      roundUp = lossy;
         fuc_pkg::RND_DOWN:    roundUp = 1'b0;
      endcase
   end

   wire        carryOut = roundUp & (&intPart);
   wire [31:0] rounded  = intPart + {31'h0, roundUp};

   // A denormal is flushed to zero first, so a negative one is not invalid.
   wire negative = signBit & ~isZero & ~isDenorm & ~isNan;
   wire saturate = (~signBit & isInf) | (normalPos & (tooBig | carryOut));
   wire invalid  = isNan | negative | saturate;
   wire inexact  = normalPos & ~saturate & lossy;

   assign intValue = saturate  ? 32'hffff_ffff :
                     normalPos ? rounded : 32'h0;

   always_comb begin
      flags                   = '0;
      flags[`FUC_BIT_INEXACT] = inexact;
      flags[`FUC_BIT_INVALID] = invalid;
      flags[`FUC_BIT_FLUSH]   = isDenorm;
   end

endmodule : fuc_convert_core

// ---- fuc_issue_model.sv ----
// Issue-side model: drives the two issue lanes the way the processor
// issue logic does. Assumes put is called just after a rising edge.
`timescale 1ns/1ps
`include "fuc_params.svh"

module fuc_issue_model (
   // Clock
   input  wire logic                          core_clk,
   // Issue lanes
   output logic [1:0]                         issueValid,
   output logic [1:0][`FUC_OP_W-1:0]          issueOpcode,
   output logic [1:0][31:0]                   sourceOperand,
   output logic [1:0]                         guardPresent,
   output logic [1:0]                         guardValue
);

   initial begin
      issueValid    = 2'b00;
      issueOpcode   = '0;
      sourceOperand = '0;
      guardPresent  = 2'b00;
      guardValue    = 2'b00;
   end

   ////////////////////////////////////////////////////////////////////////
   // One operand and an optional guard per lane and cycle.
   task automatic put(input int l, input logic [7:0] op,
         input logic [31:0] src, input logic gp, input logic gv);
      issueValid[l]    <= 1'b1;
      issueOpcode[l]   <= op;
      sourceOperand[l] <= src;
      guardPresent[l]  <= gp;
      guardValue[l]    <= gv;
   endtask : put

   // Idle lanes carry inverted junk so stale operands are never reused.
   task automatic fire();
      @(posedge core_clk);
      issueValid    <= 2'b00;
      issueOpcode   <= ~issueOpcode;
      sourceOperand <= ~sourceOperand;
      guardPresent  <= ~guardPresent;
      guardValue    <= ~guardValue;
   endtask : fire

endmodule : fuc_issue_model

// ---- testbench.sv ----
// Self-checking bench for the float-to-unsigned unit.
// Assumes fuc_params.svh on the include path and the issue model.
`timescale 1ns/1ps
`include "fuc_params.svh"

module testbench;
   logic                   core_clk = 1'b0;
   logic                   rst      = 1'b1;
   logic                   psel     = 1'b0;
   logic                   penable  = 1'b0;
   logic                   pwrite   = 1'b0;
   logic [11:0]            paddr    = '0;
   logic [31:0]            pwdata   = '0;
   logic [31:0]            prdata;
   logic                   pready;
   logic                   pslverr;
   logic [1:0]             issueValid;
   logic [1:0][7:0]        issueOpcode;
   logic [1:0][31:0]       sourceOperand;
   logic [1:0]             guardPresent;
   logic [1:0]             guardValue;
   logic [1:0]             destWrite;
   logic [1:0][31:0]       destValue;
   logic [31:0]            processorStatusWord;
   logic [31:0]            rd;
   logic                   er;
   int                     fail_count      = 0;
   int                     samples_checked = 0;
   logic [31:0] srcT[10] = '{32'h40400000, 32'h40247ae1, 32'hff4fffff,
      32'h7f800000, 32'hbfc147ae, 32'h00400000, 32'hffffffff,
      32'hffbfffff, 32'h4f7fffff, 32'h4f800000};
   logic [31:0] valT[10] = '{32'h3, 32'h2, 32'h0, 32'hffffffff, 32'h0,
      32'h0, 32'h0, 32'h0, 32'hffffff00, 32'hffffffff};
   logic [31:0] flgT[10] = '{32'h0, 32'h02, 32'h10, 32'h10, 32'h10,
      32'h20, 32'h10, 32'h10, 32'h0, 32'h10};
   logic [7:0]  opT[3]   = '{`FUC_OP_FLAGS_MODE, `FUC_OP_TRUNC,
      `FUC_OP_FLAGS_TRUNC};

   always #50 core_clk = ~core_clk;

   fuc_issue_model fuc_issue_model_i (.core_clk(core_clk),
      .issueValid(issueValid), .issueOpcode(issueOpcode),
      .sourceOperand(sourceOperand), .guardPresent(guardPresent),
      .guardValue(guardValue));

   fuc_float_to_unsigned #(.NUM_SLOTS(2)) fuc_float_to_unsigned_i (
      .core_clk(core_clk), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .issueValid(issueValid),
      .issueOpcode(issueOpcode), .sourceOperand(sourceOperand),
      .guardPresent(guardPresent), .guardValue(guardValue),
      .destWrite(destWrite), .destValue(destValue),
      .processorStatusWord(processorStatusWord));

   ////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : conclude

   task automatic check(input string what, input logic [31:0] seen,
         input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [11:0] a,
         input logic [31:0] wd);
      int k;
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (pready !== 1'b1 && k < 8);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // A write lands at the completing edge; let it settle before use.
      @(negedge core_clk);
      if (rd === rd && pready !== 1'b1 && k >= 8) begin
         fail_count++;
         conclude();
      end
   endtask : apb

   // Counts falling edges after the issue edge until the write-back.
   task automatic waitWrite(input int l, output int k);
      k = 0;
      do begin
         @(negedge core_clk);
         k++;
      end while (destWrite[l] !== 1'b1 && k < 8);
   endtask : waitWrite

   // The guard g is {present, value}.
   task automatic runOne(input int l, input logic [7:0] op,
         input logic [31:0] src, input logic [1:0] g,
         input logic [31:0] expV, input logic [31:0] expF, input logic w);
      int k;
      @(posedge core_clk);
      fuc_issue_model_i.put(l, op, src, g[1], g[0]);
      fuc_issue_model_i.fire();
      waitWrite(l, k);
      check("write", destWrite[l], w);
      if (w) begin
         check("latency", k, `FUC_LATENCY);
         check("dest", destValue[l], expV);
      end
      check("flags", processorStatusWord & `FUC_FLAG_MASK, expF);
      if (w && destWrite[l] !== 1'b1)
         conclude();
   endtask : runOne

   ////////////////////////////////////////////////////////////////////////
   initial begin
      int k;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      apb(1'b0, 12'h000, 32'h0);
      check("status reset", rd, `FUC_STATUS_RESET);
      apb(1'b1, 12'h000, 32'hffffffff);
      apb(1'b0, 12'h000, 32'h0);
      check("status mask", rd, `FUC_STATUS_MASK);
      apb(1'b1, 12'h004, 32'hffffffff);
      check("bad addr err", er, 1'b1);
      apb(1'b0, 12'h004, 32'h0);
      check("bad addr read", rd, 32'h0);
      apb(1'b1, 12'h000, 32'h0);
      check("cleared", processorStatusWord, 32'h0);
      for (int i = 0; i < 10; i++)
         for (int o = 0; o < 3; o++) begin
            apb(1'b1, 12'h000, 32'h0);
            runOne((i + o) % 2, opT[o], srcT[i], 2'b00,
               (o == 1) ? valT[i] : flgT[i],
               (o == 1) ? flgT[i] : 32'h0, 1'b1);
         end
      // Sticky flags survive a clean conversion; guards and bad opcodes.
      runOne(1, opT[1], srcT[4], 2'b00, 32'h0, 32'h10, 1'b1);
      runOne(0, opT[1], srcT[0], 2'b00, 32'h3, 32'h10, 1'b1);
      apb(1'b1, 12'h000, 32'h0);
      runOne(0, opT[1], srcT[2], 2'b10, 32'h0, 32'h0, 1'b0);
      runOne(1, opT[2], srcT[2], 2'b10, 32'h0, 32'h0, 1'b0);
      runOne(0, opT[0], srcT[3], 2'b10, 32'h0, 32'h0, 1'b0);
      runOne(1, 8'h7b, srcT[0], 2'b00, 32'h0, 32'h0, 1'b0);
      runOne(1, opT[2], srcT[5], 2'b11, 32'h20, 32'h0, 1'b1);
      runOne(0, opT[1], srcT[2], 2'b11, 32'h0, 32'h10, 1'b1);
      // Rounding mode toward plus infinity must not change truncation.
      apb(1'b1, 12'h000, 32'h200);
      check("mode", processorStatusWord, 32'h200);
      runOne(1, opT[0], srcT[1], 2'b00, 32'h02, 32'h0, 1'b1);
      runOne(0, opT[1], srcT[1], 2'b00, 32'h2, 32'h02, 1'b1);
      // Both lanes at once: flags merge by OR.
      apb(1'b1, 12'h000, 32'h0);
      @(posedge core_clk);
      fuc_issue_model_i.put(0, opT[1], srcT[1], 1'b0, 1'b0);
      fuc_issue_model_i.put(1, opT[1], srcT[5], 1'b0, 1'b0);
      fuc_issue_model_i.fire();
      waitWrite(1, k);
      check("both lanes", destWrite, 2'b11);
      check("or flags", processorStatusWord, 32'h22);
      // Back-to-back issue on one lane.
      apb(1'b1, 12'h000, 32'h0);
      @(posedge core_clk);
      for (int i = 0; i < 3; i++) begin
         fuc_issue_model_i.put(0, opT[1], srcT[i], 1'b0, 1'b0);
         if (i < 2)
            @(posedge core_clk);
      end
      fuc_issue_model_i.fire();
      waitWrite(0, k);
      for (int i = 0; i < 3; i++) begin
         check("pipe write", destWrite[0], 1'b1);
         check("pipe dest", destValue[0], valT[i]);
         @(negedge core_clk);
      end
      check("pipe flags", processorStatusWord, 32'h12);
      conclude();
   end

endmodule : testbench
